// ===== dtop_regs.vh
// register offsets, field positions, reset values and timing counts
// for the dynamic floor operating point register bank
// assumes inclusion by bare name from the design files
`ifndef DTOP_REGS_VH
`define DTOP_REGS_VH

// ****************************************
// register indices (printed offsets)
// ****************************************
`define DTOP_IDX_R1_OP        8'h33
`define DTOP_IDX_LOC_OP       8'h34
`define DTOP_IDX_R2_OP        8'h35
`define DTOP_IDX_CTRL1        8'h36
`define DTOP_IDX_CYC_LOW      8'h37
`define DTOP_IDX_LOCK         8'h38
`define DTOP_IDX_STATUS       8'h39

// ****************************************
// control register one field positions
// ****************************************
`define DTOP_CTRL1_R2_CYC_MSB 0
`define DTOP_CTRL1_RSVD       1
`define DTOP_CTRL1_R1_CAP     2
`define DTOP_CTRL1_LOC_CAP    3
`define DTOP_CTRL1_R2_CAP     4
`define DTOP_CTRL1_R1_EN      5
`define DTOP_CTRL1_LOC_EN     6
`define DTOP_CTRL1_R2_EN      7
`define DTOP_CTRL1_WMASK      8'hFD

// ****************************************
// reset values
// ****************************************
`define DTOP_OP_RESET         8'h64
`define DTOP_CTRL1_RESET      8'h00
`define DTOP_CYC_LOW_RESET    8'h00

// ****************************************
// timing
// ****************************************
`define DTOP_CLK_MHZ          25
`define DTOP_MON_CYCLE_US     1000
`define DTOP_MON_CYCLE_CLKS   (`DTOP_MON_CYCLE_US * `DTOP_CLK_MHZ)

`endif

// ===== dtop_chan.v
// one temperature channel: operating point register, throttle capture
// and dynamic floor adjustment paced by a cycle count
// assumes temperatures and the monitor tick are synchronous to CORE_CLK
`timescale 1ns/1ps
`include "dtop_regs.vh"

module dtop_chan #(
   parameter WIDTH = 8
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             wr_en,
   input  wire [WIDTH-1:0] wr_data,
   input  wire             lock,
   input  wire             cap_en,
   input  wire             throttle,
   input  wire             tick,
   input  wire             dyn_en,
   input  wire [2:0]       cycles,
   input  wire [WIDTH-1:0] temp,
   input  wire [WIDTH-1:0] floor_in,
   input  wire [WIDTH-1:0] lim_lo,
   input  wire [WIDTH-1:0] lim_hi,
   output reg  [WIDTH-1:0] op_point,
   output reg  [WIDTH-1:0] floor_out
);

   reg [2:0] wait_cnt;

   // ****************************************
   // operating point register
   // ****************************************
   // capture wins over a write in the same cycle; hardware event is newer
   always @(posedge clk) begin
      if (!rst_n) begin
         op_point <= `DTOP_OP_RESET;                    // [RULE1]
      end else if (cap_en && throttle && tick) begin  // [RULE7] [RULE9] [RULE10] [RULE16]
         op_point <= temp;
      end else if (wr_en && !lock) begin               // [RULE2]
         op_point <= wr_data;                          // [RULE8]
      end
   end

   // ****************************************
   // dynamic floor adjustment
   // ****************************************
   // one step per paced interval; a step of one degree keeps fans smooth
   always @(posedge clk) begin
      if (!rst_n) begin
         floor_out <= {WIDTH{1'b0}};
         wait_cnt  <= 3'h0;
      end else if (!dyn_en) begin
         floor_out <= floor_in;                        // [RULE13]
         wait_cnt  <= 3'h0;
      end else if (tick) begin
         if (wait_cnt < cycles) begin                  // [RULE5]
            wait_cnt <= wait_cnt + 3'h1;
         end else begin
            wait_cnt <= 3'h0;
            // hotter than target: lower floor so fans start sooner  [RULE3] [RULE11]
            if (temp > op_point && floor_out > lim_lo) begin
               floor_out <= floor_out - {{(WIDTH-1){1'b0}}, 1'b1};
            end else if (temp < op_point && floor_out < lim_hi) begin
               floor_out <= floor_out + {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule

// ===== dtop_bank.v
// register bank for dynamic minimum-temperature control, AXI4-Lite slave
// assumes all inputs synchronous to CORE_CLK except the throttle pin,
// which is brought in through a two-flop synchroniser here
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "dtop_regs.vh"

// How it works
// RULE1: the three operating point registers reset to 0x64, 100 degrees.
// RULE2: once the lock bit is set, operating point writes are dropped.
// RULE3: with dynamic control on, operating point is the target temperature.
// RULE4: control one bit 0 is remote 2 cycle MSB; low bits at 0x37.
// RULE5: the 3-bit cycle value paces monitoring cycles between adjustments; the local channel's value is tied to 0 here, cyc_low[5:3] unused.
// RULE6: control one bit 1 is reserved, reads zero, has no function.
// RULE7: bit 2 set and throttle asserted copies remote 1 temperature in.
// RULE8: bit 2 clear ignores throttle; remote 1 point keeps programmed value.
// RULE9: bit 3 set with throttle copies local temperature into local point.
// RULE10: bit 4 set with throttle copies remote 2 temperature in.
// RULE11: bit 5 enables dynamic floor adjustment on remote 1.
// RULE12: control one resets to 0x00, so capture and enable start off.
// RULE13: enable clear leaves the floor unadjusted, plain automatic control.
// RULE14: bit 6 enables dynamic floor adjustment on the local channel.
// RULE15: bit 7 enables dynamic floor adjustment on remote 2.
// RULE16: captures use synchronised throttle, once per monitor cycle while held.
module dtop_bank #(
   parameter MON_CYCLE_CLKS = `DTOP_MON_CYCLE_CLKS
) (
   input  wire        CORE_CLK,
   input  wire        RST_N,
   input  wire [7:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output reg         S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output reg         S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [7:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output reg         S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   input  wire        THERMAL_THROTTLE_SIGNAL_N,
   input  wire [7:0]  REMOTE1_TEMP,
   input  wire [7:0]  LOCAL_TEMP,
   input  wire [7:0]  REMOTE2_TEMP,
   input  wire [23:0] FLOOR_IN,
   input  wire [23:0] LIMIT_LOW,
   input  wire [23:0] LIMIT_HIGH,
   output reg  [23:0] FLOOR_OUT,
   output reg  [2:0]  DYNAMIC_ACTIVE
);

   localparam [1:0] RESP_OKAY   = 2'b00;
   localparam [1:0] RESP_SLVERR = 2'b10;
   localparam [31:0] TICK_LAST  = MON_CYCLE_CLKS - 1;

   reg  [7:0]  ctrl_one;
   reg  [7:0]  cyc_low;
   reg         lock;
   reg         thr_meta;
   reg         thr_sync;
   reg  [31:0] tick_cnt;
   reg         tick;
   reg  [7:0]  aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         aw_held;
   reg         w_held;
   reg  [7:0]  next_rdata;
   reg         next_rerr;
   wire        wr_go;
   wire [7:0]  wr_idx;
   wire [7:0]  rd_idx;
   wire [23:0] op_points;
   wire [23:0] floors;
   wire [8:0]  cycle_sets;

   // ****************************************
   // throttle synchroniser and monitor tick
   // ****************************************
   // pin is active low and asynchronous; second flop alone is used
   always @(posedge CORE_CLK) begin
      if (!RST_N) begin
         thr_meta <= 1'b0;
         thr_sync <= 1'b0;
      end else begin
         thr_meta <= ~THERMAL_THROTTLE_SIGNAL_N;
         thr_sync <= thr_meta;                          // [RULE16]
      end
   end

   // free-running monitoring cycle; one pulse per period
   always @(posedge CORE_CLK) begin
      if (!RST_N) begin
         tick_cnt <= 32'h0;
         tick     <= 1'b0;
      end else if (tick_cnt >= TICK_LAST) begin
         tick_cnt <= 32'h0;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
         tick     <= 1'b0;
      end
   end

   // ****************************************
   // AXI4-Lite write path
   // ****************************************
   // address and data latched independently, either order
   always @(posedge CORE_CLK) begin
      if (!RST_N) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= RESP_OKAY;
      end else begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         if (S_AXI_AWVALID && !aw_held && !S_AXI_AWREADY && !S_AXI_BVALID) begin
            S_AXI_AWREADY <= 1'b1;
         end
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && !w_held && !S_AXI_WREADY && !S_AXI_BVALID) begin
            S_AXI_WREADY <= 1'b1;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (wr_idx >= `DTOP_IDX_R1_OP && wr_idx <= `DTOP_IDX_LOCK) ?
                            RESP_OKAY : RESP_SLVERR;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   assign wr_go  = aw_held && w_held && !S_AXI_BVALID;
   assign wr_idx = {2'b00, aw_addr[7:2]};

   // ****************************************
   // control registers
   // ****************************************
   // only the low byte lane carries register data
   always @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ctrl_one <= `DTOP_CTRL1_RESET;                   // [RULE12]
         cyc_low  <= `DTOP_CYC_LOW_RESET;
         lock     <= 1'b0;
      end else if (wr_go && w_strb[0]) begin
         if (wr_idx == `DTOP_IDX_CTRL1) begin
            ctrl_one <= w_data[7:0] & `DTOP_CTRL1_WMASK;  // [RULE6]
         end else if (wr_idx == `DTOP_IDX_CYC_LOW) begin
            cyc_low <= w_data[7:0];
         end else if (wr_idx == `DTOP_IDX_LOCK && w_data[0]) begin
            lock <= 1'b1;                                 // sticky until reset
         end
      end
   end

   // remote 2 cycle value splits across two registers  [RULE4]
   assign cycle_sets = {ctrl_one[`DTOP_CTRL1_R2_CYC_MSB], cyc_low[7:6],
                        3'h0,
                        cyc_low[2:0]};

   // ****************************************
   // per-channel operating point and floor logic
   // ****************************************
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
         dtop_chan #(.WIDTH(8)) u_chan (
            .clk       (CORE_CLK),
            .rst_n     (RST_N),
            .wr_en     (wr_go && w_strb[0] && wr_idx == `DTOP_IDX_R1_OP + ch),
            .wr_data   (w_data[7:0]),
            .lock      (lock),                                      // [RULE2]
            .cap_en    (ctrl_one[`DTOP_CTRL1_R1_CAP + ch]),          // [RULE8]
            .throttle  (thr_sync),
            .tick      (tick),
            .dyn_en    (ctrl_one[`DTOP_CTRL1_R1_EN + ch]),  // [RULE11] [RULE14] [RULE15]
            .cycles    (cycle_sets[ch*3 +: 3]),
            .temp      (ch == 0 ? REMOTE1_TEMP : (ch == 1 ? LOCAL_TEMP : REMOTE2_TEMP)),
            .floor_in  (FLOOR_IN[ch*8 +: 8]),
            .lim_lo    (LIMIT_LOW[ch*8 +: 8]),
            .lim_hi    (LIMIT_HIGH[ch*8 +: 8]),
            .op_point  (op_points[ch*8 +: 8]),
            .floor_out (floors[ch*8 +: 8])
         );
      end
   endgenerate

   // registered outputs toward the fan loop
   always @(posedge CORE_CLK) begin
      if (!RST_N) begin
         FLOOR_OUT      <= 24'h0;
         DYNAMIC_ACTIVE <= 3'h0;
      end else begin
         FLOOR_OUT      <= floors;
         DYNAMIC_ACTIVE <= ctrl_one[7:5];                 // [RULE3]
      end
   end

   // ****************************************
   // AXI4-Lite read path
   // ****************************************
   // read decode; unmapped words answer SLVERR with zero data
   assign rd_idx = {2'b00, S_AXI_ARADDR[7:2]};

   always @* begin
      next_rdata = 8'h00;
      next_rerr  = 1'b0;
      if (rd_idx == `DTOP_IDX_R1_OP) begin
         next_rdata = op_points[7:0];
      end else if (rd_idx == `DTOP_IDX_LOC_OP) begin
         next_rdata = op_points[15:8];
      end else if (rd_idx == `DTOP_IDX_R2_OP) begin
         next_rdata = op_points[23:16];
      end else if (rd_idx == `DTOP_IDX_CTRL1) begin
         next_rdata = ctrl_one;                           // [RULE6]
      end else if (rd_idx == `DTOP_IDX_CYC_LOW) begin
         next_rdata = cyc_low;
      end else if (rd_idx == `DTOP_IDX_LOCK) begin
         next_rdata = {7'h00, lock};
      end else if (rd_idx == `DTOP_IDX_STATUS) begin
         next_rdata = {6'h00, tick, thr_sync};
      end else begin
         next_rerr = 1'b1;
      end
   end

   // one read at a time; ARREADY pulses for one cycle
   always @(posedge CORE_CLK) begin
      if (!RST_N) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0;
         S_AXI_RRESP   <= RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= 1'b0;
         if (S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= {24'h0, next_rdata};
            S_AXI_RRESP   <= next_rerr ? RESP_SLVERR : RESP_OKAY;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

endmodule

// ===== dtop_bank_assertions.sv
// checker for the dynamic floor register bank, bound to its top module
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module dtop_bank_chk #(
   parameter MON_CYCLE_CLKS = 8
) (
   input wire        CORE_CLK,
   input wire        RST_N,
   input wire [7:0]  S_AXI_ARADDR,
   input wire        S_AXI_ARVALID,
   input wire        S_AXI_ARREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire [1:0]  S_AXI_RRESP,
   input wire        S_AXI_RVALID,
   input wire        S_AXI_RREADY,
   input wire        S_AXI_AWREADY,
   input wire        S_AXI_WREADY,
   input wire        S_AXI_BVALID,
   input wire        S_AXI_BREADY,
   input wire [23:0] FLOOR_IN,
   input wire [23:0] FLOOR_OUT,
   input wire [2:0]  DYNAMIC_ACTIVE
);
   // ****************************************
   // helpers
   // ****************************************
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // a read is taken only when nothing is pending
   wire       rd_go = S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
   wire [5:0] rd_ix = S_AXI_ARADDR[7:2];

   AST_AW_PULSE: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
      else $error("write address ready held too long");
   AST_W_ANSWER: assert property (S_AXI_AWREADY && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
      else $error("write response late");
   AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped early");
   AST_R_ANSWER: assert property (rd_go |=> S_AXI_ARREADY && S_AXI_RVALID)
      else $error("read answer late");
   AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data not held");
   AST_R_MAPPED: assert property (rd_go && rd_ix >= 6'h33 && rd_ix <= 6'h38
      |=> S_AXI_RRESP == 2'b00)
      else $error("mapped read refused");
   AST_R_UNMAPPED: assert property (rd_go && (rd_ix < 6'h33 || rd_ix > 6'h39)
      |=> S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h0)
      else $error("unmapped read accepted");
   AST_RSVD_ZERO: assert property (rd_go && rd_ix == 6'h36 |=> !S_AXI_RDATA[1])
      else $error("reserved bit reads one");
   AST_RESET_OFF: assert property ($rose(RST_N)
      |-> DYNAMIC_ACTIVE == 3'h0 && FLOOR_OUT == 24'h0)
      else $error("dynamic control on after reset");
   // floor passes through the channel and the output flop: two clocks of lag
   AST_FLOOR_OFF: assert property ($past(RST_N) && $past(RST_N, 2) && !$past(DYNAMIC_ACTIVE[0])
      |-> FLOOR_OUT[7:0] == $past(FLOOR_IN[7:0], 2))
      else $error("floor adjusted while disabled");

   // main scenarios reached
   cover property (rd_go && rd_ix == 6'h36);
   cover property (S_AXI_BVALID && S_AXI_BREADY);
   cover property (DYNAMIC_ACTIVE == 3'h7);
endmodule

bind dtop_bank dtop_bank_chk #(.MON_CYCLE_CLKS(MON_CYCLE_CLKS)) dtop_bank_chk_i (
   .CORE_CLK, .RST_N, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
   .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_AWREADY, .S_AXI_WREADY,
   .S_AXI_BVALID, .S_AXI_BREADY, .FLOOR_IN, .FLOOR_OUT, .DYNAMIC_ACTIVE);

// ===== dtop_bank_bench.sv
// self-checking bench for the dynamic floor register bank
// assumes a monitor tick shortened to 8 clocks
`timescale 1ns/1ps
module dtop_bank_bench;
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
   reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   reg         arvalid = 1'b0, rready = 1'b0, thr_n = 1'b1;
   reg  [31:0] wdata = 32'h0;
   reg  [23:0] temps = 24'h5C5B5A, fl_in = 24'h121430;
   reg  [23:0] lim_lo = 24'h101010, lim_hi = 24'h404040;
   wire        awready, wready, bvalid, arready, rvalid;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [23:0] fl_out;
   wire [2:0]  dyn_act;
   integer     err_count = 0, total_checks = 0;

   // 25 MHz core clock
   always #20 clk = ~clk;

   dtop_bank #(.MON_CYCLE_CLKS(8)) dtop_bank_i (
      .CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .THERMAL_THROTTLE_SIGNAL_N(thr_n), .REMOTE1_TEMP(temps[7:0]),
      .LOCAL_TEMP(temps[15:8]), .REMOTE2_TEMP(temps[23:16]), .FLOOR_IN(fl_in),
      .LIMIT_LOW(lim_lo), .LIMIT_HIGH(lim_hi), .FLOOR_OUT(fl_out), .DYNAMIC_ACTIVE(dyn_act));

   // ****************************************
   // shared tasks
   // ****************************************
   task conclude;
      begin
         $display("checks %0d errors %0d", total_checks, err_count);
         if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   // address and data offered together, each dropped when taken
   task automatic wr(input [7:0] ix, input [7:0] d, input [1:0] er);
      reg a, w;
      begin
         a = 1'b0;
         w = 1'b0;
         @(posedge clk);
         awaddr <= {ix[5:0], 2'b00};
         wdata <= {24'h0, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         while (!(a && w)) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            a = a | (awready === 1'b1);
            w = w | (wready === 1'b1);
         end
         while (bvalid !== 1'b1) @(posedge clk);
         bready <= 1'b0;
         chk("bresp", er, bresp);
      end
   endtask

   task automatic rd(input [7:0] ix, input [7:0] ed, input [1:0] er);
      begin
         @(posedge clk);
         araddr <= {ix[5:0], 2'b00};
         arvalid <= 1'b1;
         rready <= 1'b1;
         @(posedge clk);
         while (rvalid !== 1'b1) @(posedge clk);
         arvalid <= 1'b0;
         rready <= 1'b0;
         chk("rresp", er, rresp);
         chk("rdata", {24'h0, ed}, rdata);
      end
   endtask

   // held well past a tick so the synchronised level is seen
   task throttle;
      begin
         @(posedge clk);
         thr_n <= 1'b0;
         repeat (40) @(posedge clk);
         thr_n <= 1'b1;
         repeat (8) @(posedge clk);
      end
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task t_reset;
      reg [7:0] i;
      begin
         for (i = 8'h33; i < 8'h36; i = i + 1) rd(i, 8'h64, 2'b00);
         rd(8'h36, 8'h00, 2'b00);
         chk("active", 32'h0, dyn_act);
      end
   endtask

   // answers must stand while the master holds its ready lines low
   task t_stall;
      begin
         @(posedge clk);
         araddr <= {6'h33, 2'b00};
         arvalid <= 1'b1;
         @(posedge clk);
         while (arready !== 1'b1) @(posedge clk);
         arvalid <= 1'b0;
         repeat (3) @(posedge clk);
         chk("rvalid_held", 32'h1, rvalid);
         rready <= 1'b1;
         @(posedge clk);
         rready <= 1'b0;
         chk("rresp_held", 32'h0, rresp);
         chk("rdata_held", 32'h64, rdata);
         @(posedge clk);
         awaddr <= {6'h34, 2'b00};
         wdata <= 32'h41;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         @(posedge clk);
         while (awready !== 1'b1 || wready !== 1'b1) @(posedge clk);
         awvalid <= 1'b0;
         wvalid <= 1'b0;
         repeat (3) @(posedge clk);
         chk("bvalid_held", 32'h1, bvalid);
         bready <= 1'b1;
         @(posedge clk);
         bready <= 1'b0;
         chk("bresp_held", 32'h0, bresp);
         rd(8'h34, 8'h41, 2'b00);
      end
   endtask

   task t_ctrl;
      begin
         wr(8'h36, 8'hFF, 2'b00);
         rd(8'h36, 8'hFD, 2'b00);
         chk("active", 32'h7, dyn_act);
         wr(8'h36, 8'h00, 2'b00);
         repeat (3) @(posedge clk);
         chk("active", 32'h0, dyn_act);
         chk("floor", fl_in, fl_out);
      end
   endtask

   task t_unmapped;
      begin
         wr(8'h10, 8'hAA, 2'b10);
         wr(8'h39, 8'h00, 2'b10);
         rd(8'h10, 8'h00, 2'b10);
         rd(8'h3A, 8'h00, 2'b10);
      end
   endtask

   task t_capture;
      begin
         wr(8'h34, 8'h3C, 2'b00);
         wr(8'h36, 8'h14, 2'b00);
         throttle();
         rd(8'h33, 8'h5A, 2'b00);
         rd(8'h34, 8'h3C, 2'b00);
         rd(8'h35, 8'h5C, 2'b00);
         temps <= 24'h6C6B6A;
         wr(8'h36, 8'h08, 2'b00);
         throttle();
         rd(8'h33, 8'h5A, 2'b00);
         rd(8'h34, 8'h6B, 2'b00);
         rd(8'h35, 8'h5C, 2'b00);
      end
   endtask

   // remote 2 paced at cycle value 6, the others every tick
   task t_dynamic;
      begin
         temps <= 24'h707070;
         wr(8'h37, 8'h80, 2'b00);
         rd(8'h37, 8'h80, 2'b00);
         wr(8'h36, 8'hE1, 2'b00);
         repeat (40) @(posedge clk);
         chk("r2_paced", 32'h1, fl_out[23:16] > 8'h10);
         chk("r1_moving", 32'h1, fl_out[7:0] < 8'h30);
         repeat (600) @(posedge clk);
         chk("floor", 32'h101010, fl_out);
         wr(8'h36, 8'h00, 2'b00);
      end
   endtask

   task t_lock;
      begin
         wr(8'h33, 8'h77, 2'b00);
         rd(8'h33, 8'h77, 2'b00);
         wr(8'h38, 8'h01, 2'b00);
         rd(8'h38, 8'h01, 2'b00);
         wr(8'h33, 8'h11, 2'b00);
         rd(8'h33, 8'h77, 2'b00);
         wr(8'h35, 8'h22, 2'b00);
         rd(8'h35, 8'h5C, 2'b00);
      end
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_stall();
      t_ctrl();
      t_unmapped();
      t_capture();
      t_dynamic();
      t_lock();
      conclude();
   end

   // whole run needs about a thousand clocks
   initial begin
      repeat (20000) @(posedge clk);
      err_count = err_count + 1;
      conclude();
   end
endmodule
